// [cip_arbiter.sv]
/*
 * Shared constants for the interrupt prioritizer, and the combinational
 * arbiter that picks the winning vector among pending requests.
 * Assumes request lines are already gated by each peripheral's own enable
 * and that the executing-level flags come from the sequencer in cip_top.
 */
`timescale 1ns/1ps

package cip_pkg;
    localparam int            NUM_VEC       = 64;
    localparam int            VEC_W         = 8;
    localparam int            ADDR_W        = 16;
    // fixed non-maskable set: vector 1 only, not configurable by software
    localparam logic [63:0]   NMI_VEC_MASK  = 64'h0000_0000_0000_0002;
    localparam logic [15:0]   BOOT_VEC_BASE = 16'h0000;
    localparam logic [15:0]   VEC_STRIDE    = 16'h0002;
    localparam logic [7:0]    CVT_NMI_VEC   = 8'h01;
    localparam logic [7:0]    CVT_LVL1_VEC  = 8'h02;
    localparam logic [7:0]    CVT_LVL0_VEC  = 8'h03;
    localparam logic [7:0]    PRIO_BASE_RST = 8'h00;
    // response and return timing in cycles of sys_clk, with the flash size and PC width that select the jump and return lengths
    localparam int            FLASH_KB       = 32;
    localparam int            SMALL_FLASH_KB = 8;
    localparam int            PC_BITS        = 14;
    localparam int            WIDE_PC_BITS   = 16;
    localparam logic [7:0]    PUSH_CYC       = 8'h02;
    localparam logic [7:0]    JMP_CYC        = 8'h03;
    localparam logic [7:0]    RJMP_CYC       = 8'h02;
    localparam logic [7:0]    WAKE_EXTRA_CYC = 8'h05;
    localparam logic [7:0]    RET_NARROW_CYC = 8'h04;
    localparam logic [7:0]    RET_WIDE_CYC   = 8'h05;
    localparam logic [7:0]    JUMP_LEN = (FLASH_KB > SMALL_FLASH_KB) ? JMP_CYC : RJMP_CYC;
    localparam logic [7:0]    RET_LEN  = (PC_BITS > WIDE_PC_BITS) ? RET_WIDE_CYC
                                                                  : RET_NARROW_CYC;
    localparam logic [7:0]    CNT_ONE  = 8'h01;
    typedef enum logic [1:0] {
        CIP_LVL_NORMAL = 2'h0,
        CIP_LVL_HIGH   = 2'h1,
        CIP_LVL_NMI    = 2'h2
    } cip_lvl_type;
endpackage : cip_pkg

module cip_arbiter
    import cip_pkg::*;
(
    input  wire logic [NUM_VEC-1:0] pending,
    input  wire logic               global_enable,
    input  wire logic               nmi_ex,
    input  wire logic               lvl1_ex,
    input  wire logic               lvl0_ex,
    input  wire logic [VEC_W-1:0]   high_level_vector,
    input  wire logic [VEC_W-1:0]   normal_priority_base,
    output logic                    win_valid,
    output logic [VEC_W-1:0]        win_vec,
    output cip_lvl_type             win_lvl
);

    // index bits of a vector number within the table
    localparam int IDX_W = $clog2(NUM_VEC);

    ////////////////////////////////////////////////////////////////////////////
    // first set bit after base, wrapping; base itself is searched last
    function automatic logic [VEC_W:0] first_after(input logic [NUM_VEC-1:0] m,
                                                   input logic [VEC_W-1:0]   base);
        logic [VEC_W:0] res;
        int             idx;
        res = '0;
        for (int k = NUM_VEC; k >= 1; k--)
        begin
            idx = (int'(base) + k) % NUM_VEC;
            if (m[idx])
                res = {1'b1, VEC_W'(idx)};
        end
        return res;
    endfunction : first_after

    logic [NUM_VEC-1:0] hv_onehot;
    logic [NUM_VEC-1:0] nmi_pend;
    logic [NUM_VEC-1:0] lvl0_pend;
    logic               hv_ok;
    logic [VEC_W:0]     nmi_pick;
    logic [VEC_W:0]     lvl0_pick;
    logic               lvl1_go;
    logic               lvl0_go;

    // one level-1 vector; reset and non-maskable vectors cannot be raised
    always_comb
    begin
        hv_onehot = '0;
        hv_ok     = (int'(high_level_vector) < NUM_VEC) && (high_level_vector != '0);
        if (hv_ok)
            hv_onehot[high_level_vector[IDX_W-1:0]] = 1'b1;
        hv_ok     = hv_ok && ((hv_onehot & NMI_VEC_MASK) == '0);
    end

    assign nmi_pend  = pending & NMI_VEC_MASK;
    assign lvl0_pend = pending & ~NMI_VEC_MASK & ~(hv_ok ? hv_onehot : '0)
                       & ~{{(NUM_VEC-1){1'b0}}, 1'b1};
    assign nmi_pick  = first_after(nmi_pend, PRIO_BASE_RST);
    assign lvl0_pick = first_after(lvl0_pend, normal_priority_base);

    // a level wins only above the level of any handler in progress
    assign lvl1_go = hv_ok && pending[high_level_vector[IDX_W-1:0]] && global_enable
                     && !nmi_ex && !lvl1_ex;
    assign lvl0_go = lvl0_pick[VEC_W] && global_enable
                     && !nmi_ex && !lvl1_ex && !lvl0_ex;

    always_comb
    begin
        win_valid = 1'b0;
        win_vec   = '0;
        win_lvl   = CIP_LVL_NORMAL;
        if (nmi_pick[VEC_W] && !nmi_ex)
        begin
            win_valid = 1'b1;
            win_vec   = nmi_pick[VEC_W-1:0];
            win_lvl   = CIP_LVL_NMI;
        end
        else if (lvl1_go)
        begin
            win_valid = 1'b1;
            win_vec   = high_level_vector;
            win_lvl   = CIP_LVL_HIGH;
        end
        else if (lvl0_go)
        begin
            win_valid = 1'b1;
            win_vec   = lvl0_pick[VEC_W-1:0];
            win_lvl   = CIP_LVL_NORMAL;
        end
    end

endmodule : cip_arbiter

// [cip_top.sv]
/*
 * Interrupt prioritizer between peripheral request lines and the CPU core:
 * arbitration, executing-level state, vector placement and the response,
 * wake and return timing sequence.
 * Assumes the CPU pulses instr_done at each instruction end, answers
 * int_req with int_ack, pulses return_from_handler_exec on return, and that every input
 * is synchronous to sys_clk.
 */

`timescale 1ns/1ps

// Notes on behaviour
// - request waits until its level outranks handler
// - one instruction runs after return before servicing
// - maskable requests need the global enable set
// - servicing never clears peripheral interrupt flags
// - vector base select picks application or boot
// - finish one, push two, jump three cycles
// - multi-cycle instruction completes before vectoring
// - wake adds five cycles plus start-up time
// - return takes four or five cycles popping
// - three levels: non-maskable, high, normal
// - high preempts normal; normal resumes afterwards
// - non-maskable ignores and never alters global enable
// - nothing preempts a running non-maskable handler
// - simultaneous non-maskable: lowest vector first
// - fixed non-maskable set, still needs enabling
// - one vector selectable as high level
// - round-robin enable bit turns rotation on
// - base vector lowest, next one highest, wrapping
// - round-robin loads base with acknowledged vector
// - compact table uses vectors one, two, three
// - executing flags restore previous level on return

module cip_top
    import cip_pkg::*;
(
    input  wire logic               sys_clk,
    input  wire logic               reset_n,
    input  wire logic [NUM_VEC-1:0] irq_lines,
    input  wire logic               global_enable,
    input  wire logic               vector_base_select,
    input  wire logic               compact_table_enable,
    input  wire logic               round_robin_enable,
    input  wire logic [VEC_W-1:0]   high_level_vector,
    input  wire logic               prio_base_wr,
    input  wire logic [VEC_W-1:0]   prio_base_wdata,
    input  wire logic [ADDR_W-1:0]  app_vector_base,
    input  wire logic               instr_done,
    input  wire logic               cpu_sleeping,
    input  wire logic [7:0]         wake_startup_cycles,
    input  wire logic               int_ack,
    input  wire logic               return_from_handler_exec,
    output logic                    int_req,
    output logic [VEC_W-1:0]        int_vector,
    output logic                    seq_push_pc,
    output logic                    seq_jump,
    output logic                    seq_pop_pc,
    output logic [VEC_W-1:0]        active_vector,
    output logic [ADDR_W-1:0]       vector_addr,
    output logic [VEC_W-1:0]        normal_priority_base,
    output logic                    nmi_executing,
    output logic                    lvl1_executing,
    output logic                    lvl0_executing
);

    typedef enum logic [6:0] {
        ST_IDLE   = 7'h01,
        ST_WAKE   = 7'h02,
        ST_FINISH = 7'h04,
        ST_PUSH   = 7'h08,
        ST_JUMP   = 7'h10,
        ST_RET    = 7'h20,
        ST_STEP   = 7'h40
    } cip_state_type;

    cip_state_type     state_ff;
    cip_state_type     nxt_state;
    logic [7:0]        cnt_ff;
    logic [7:0]        nxt_cnt;
    logic              nmi_ex_ff;
    logic              lvl1_ex_ff;
    logic              lvl0_ex_ff;
    logic [VEC_W-1:0]  base_ff;
    logic [VEC_W-1:0]  vec_ff;
    logic [ADDR_W-1:0] addr_ff;
    logic              win_valid;
    logic [VEC_W-1:0]  win_vec;
    cip_lvl_type       win_lvl;
    logic              take;
    logic              ret_take;
    logic              cnt_last;
    logic [VEC_W-1:0]  table_vec;
    logic [ADDR_W-1:0] table_base;

    ////////////////////////////////////////////////////////////////////////////
    // arbitration over the raw request lines; flags stay with the peripheral
    cip_arbiter u_arb (
        .pending              (irq_lines),
        .global_enable        (global_enable),
        .nmi_ex               (nmi_ex_ff),
        .lvl1_ex              (lvl1_ex_ff),
        .lvl0_ex              (lvl0_ex_ff),
        .high_level_vector    (high_level_vector),
        .normal_priority_base (base_ff),
        .win_valid            (win_valid),
        .win_vec              (win_vec),
        .win_lvl              (win_lvl)
    );

    ////////////////////////////////////////////////////////////////////////////
    // request to the core only between sequences, never in the step after return
    assign int_req    = win_valid && (state_ff == ST_IDLE);
    assign int_vector = win_vec;
    assign take       = int_req && int_ack;
    assign ret_take   = (state_ff == ST_IDLE) && return_from_handler_exec
                        && (nmi_ex_ff || lvl1_ex_ff || lvl0_ex_ff);
    assign cnt_last   = (cnt_ff == CNT_ONE);

    // compact table folds each level onto a single vector
    always_comb
    begin
        table_vec = win_vec;
        if (compact_table_enable)
        begin
            unique case (win_lvl)
                CIP_LVL_NMI:    table_vec = CVT_NMI_VEC;
                CIP_LVL_HIGH:   table_vec = CVT_LVL1_VEC;
                CIP_LVL_NORMAL: table_vec = CVT_LVL0_VEC;
                default:        table_vec = win_vec;
            endcase
        end
    end

    assign table_base = vector_base_select ? BOOT_VEC_BASE : app_vector_base;

    ////////////////////////////////////////////////////////////////////////////
    // response, wake and return sequencer
    always_comb
    begin
        nxt_state = state_ff;
        nxt_cnt   = cnt_ff;
        unique case (state_ff)
            ST_IDLE:
            begin
                if (take && cpu_sleeping)
                begin
                    nxt_state = ST_WAKE;
                    nxt_cnt   = WAKE_EXTRA_CYC + wake_startup_cycles;
                end
                else if (take)
                    nxt_state = ST_FINISH;
                else if (ret_take)
                begin
                    nxt_state = ST_RET;
                    nxt_cnt   = RET_LEN;
                end
            end
            ST_WAKE:
            begin
                nxt_cnt = cnt_ff - CNT_ONE;
                if (cnt_last)
                begin
                    nxt_state = ST_PUSH;
                    nxt_cnt   = PUSH_CYC;
                end
            end
            ST_FINISH:
            begin
                // a multi-cycle instruction holds the sequence here
                if (instr_done)
                begin
                    nxt_state = ST_PUSH;
                    nxt_cnt   = PUSH_CYC;
                end
            end
            ST_PUSH:
            begin
                nxt_cnt = cnt_ff - CNT_ONE;
                if (cnt_last)
                begin
                    nxt_state = ST_JUMP;
                    nxt_cnt   = JUMP_LEN;
                end
            end
            ST_JUMP:
            begin
                nxt_cnt = cnt_ff - CNT_ONE;
                if (cnt_last)
                    nxt_state = ST_IDLE;
            end
            ST_RET:
            begin
                nxt_cnt = cnt_ff - CNT_ONE;
                if (cnt_last)
                    nxt_state = ST_STEP;
            end
            ST_STEP:
            begin
                // resumed code gets one whole instruction first
                if (instr_done)
                    nxt_state = ST_IDLE;
            end
            default:
            begin
                nxt_state = ST_IDLE;
                nxt_cnt   = '0;
            end
        endcase
    end

    // sequencer state
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            state_ff <= ST_IDLE;
            cnt_ff   <= '0;
        end
        else
        begin
            state_ff <= nxt_state;
            cnt_ff   <= nxt_cnt;
        end
    end

    // per-level executing flags; return clears the highest one set
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            nmi_ex_ff  <= 1'b0;
            lvl1_ex_ff <= 1'b0;
            lvl0_ex_ff <= 1'b0;
        end
        else if (take)
        begin
            // global enable is not used here and never written back; only the arbiter and a_gie_gate read it
            nmi_ex_ff  <= nmi_ex_ff  || (win_lvl == CIP_LVL_NMI);
            lvl1_ex_ff <= lvl1_ex_ff || (win_lvl == CIP_LVL_HIGH);
            lvl0_ex_ff <= lvl0_ex_ff || (win_lvl == CIP_LVL_NORMAL);
        end
        else if ((state_ff == ST_RET) && cnt_last)
        begin
            if (nmi_ex_ff)
                nmi_ex_ff <= 1'b0;
            else if (lvl1_ex_ff)
                lvl1_ex_ff <= 1'b0;
            else
                lvl0_ex_ff <= 1'b0;
        end
    end

    // normal priority base; hardware rotation wins over a software write
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
            base_ff <= PRIO_BASE_RST;
        else if (take && round_robin_enable && (win_lvl == CIP_LVL_NORMAL))
            base_ff <= win_vec;
        else if (prio_base_wr)
            base_ff <= prio_base_wdata;
    end

    // vector latched on acknowledge so later request changes cannot move it
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            vec_ff  <= '0;
            addr_ff <= '0;
        end
        else if (take)
        begin
            vec_ff  <= table_vec;
            addr_ff <= table_base + ADDR_W'(table_vec) * VEC_STRIDE;
        end
    end

    assign seq_push_pc          = (state_ff == ST_PUSH);
    assign seq_jump             = (state_ff == ST_JUMP);
    assign seq_pop_pc           = (state_ff == ST_RET);
    assign active_vector        = vec_ff;
    assign vector_addr          = addr_ff;
    assign normal_priority_base = base_ff;
    assign nmi_executing        = nmi_ex_ff;
    assign lvl1_executing       = lvl1_ex_ff;
    assign lvl0_executing       = lvl0_ex_ff;

    ////////////////////////////////////////////////////////////////////////////
    // checks on the sequencer and arbitration
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!reset_n);

    property p_gie_gate;
        int_req && (win_lvl != CIP_LVL_NMI) |-> global_enable;
    endproperty
    a_gie_gate: assert property (p_gie_gate)
        else $error("maskable request raised with global enable clear");

    property p_nmi_alone;
        nmi_ex_ff |-> !int_req;
    endproperty
    a_nmi_alone: assert property (p_nmi_alone)
        else $error("request raised during non-maskable handler");

    property p_normal_waits;
        int_req && (win_lvl == CIP_LVL_NORMAL) |-> !lvl0_ex_ff && !lvl1_ex_ff;
    endproperty
    a_normal_waits: assert property (p_normal_waits)
        else $error("normal request raised over a running handler");

    property p_finish_hold;
        (state_ff == ST_FINISH) && !instr_done |=> (state_ff == ST_FINISH);
    endproperty
    a_finish_hold: assert property (p_finish_hold)
        else $error("vectoring began before instruction completed");

    property p_push_jump;
        $rose(seq_push_pc) |-> seq_push_pc [*2] ##1 seq_jump [*3] ##1 (state_ff == ST_IDLE);
    endproperty
    a_push_jump: assert property (p_push_jump)
        else $error("push or jump length wrong");

    property p_wake;
        take && cpu_sleeping && (wake_startup_cycles == 8'h00)
            |=> (state_ff == ST_WAKE) [*5] ##1 seq_push_pc;
    endproperty
    a_wake: assert property (p_wake)
        else $error("wake delay not five cycles");

    property p_ret_len;
        $rose(seq_pop_pc) |-> seq_pop_pc [*4] ##1 (state_ff == ST_STEP);
    endproperty
    a_ret_len: assert property (p_ret_len)
        else $error("return length wrong");

    property p_step_blocks;
        (state_ff == ST_STEP) |-> !int_req;
    endproperty
    a_step_blocks: assert property (p_step_blocks)
        else $error("request raised before one instruction after return");

    property p_rr_load;
        take && round_robin_enable && (win_lvl == CIP_LVL_NORMAL)
            |=> (base_ff == $past(win_vec));
    endproperty
    a_rr_load: assert property (p_rr_load)
        else $error("round-robin base not loaded");

    property p_cvt_normal;
        take && compact_table_enable && (win_lvl == CIP_LVL_NORMAL)
            |=> (vec_ff == CVT_LVL0_VEC);
    endproperty
    a_cvt_normal: assert property (p_cvt_normal)
        else $error("compact table normal vector wrong");

    property p_restore;
        (state_ff == ST_RET) && cnt_last && lvl1_ex_ff && lvl0_ex_ff && !nmi_ex_ff
            |=> !lvl1_ex_ff && lvl0_ex_ff;
    endproperty
    a_restore: assert property (p_restore)
        else $error("preempted normal level not restored");

    c_nested: cover property (take && (win_lvl == CIP_LVL_HIGH) && lvl0_ex_ff);
    c_nmi:    cover property (take && (win_lvl == CIP_LVL_NMI));
    c_wake:   cover property (take && cpu_sleeping);
    c_ret:    cover property ($fell(seq_pop_pc));

endmodule : cip_top

// [cip_cpu_model.sv]
/*
 * Behavioural CPU core facing the prioritizer: acknowledges requests and
 * ends an instruction every second cycle.
 * Assumes the bench opens the acknowledge window and may hold the core
 * in a long instruction.
 */
`timescale 1ns/1ps

module cip_cpu_model
(
    input  wire logic sys_clk,
    input  wire logic reset_n,
    input  wire logic int_req,
    input  wire logic ack_en,
    input  wire logic hold,
    output logic      int_ack,
    output logic      instr_done
);
    logic tog_ff;

    ////////////////////////////////////////////////////////////////////////////
    // two-cycle instructions; hold stretches one to test late vectoring
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
            tog_ff <= 1'h0;
        else
            tog_ff <= ~tog_ff;
    end
    assign instr_done = tog_ff & ~hold;

    // accept in the same cycle, only while the bench lets the core listen
    assign int_ack = int_req & ack_en;
endmodule : cip_cpu_model

// [cpu_interrupt_prioritizer_tb.sv]
/*
 * Self-checking bench for cip_top with the behavioural core model.
 * Assumes a 200 MHz clock and that peripherals gate their own lines.
 */
`timescale 1ns/1ps

module cpu_interrupt_prioritizer_tb;
    import cip_pkg::*;
    logic        sys_clk = 0, reset_n = 0, global_enable = 0, hold = 0, ack_en = 0;
    logic        vector_base_select = 0, compact_table_enable = 0, round_robin_enable = 0;
    logic        prio_base_wr = 0, cpu_sleeping = 0, return_from_handler_exec = 0;
    logic [63:0] irq_lines = '0;
    logic [7:0]  high_level_vector = 0, prio_base_wdata = 0, wake_startup_cycles = 0;
    logic [15:0] app_vector_base = 16'h0400;
    logic        int_req, seq_push_pc, seq_jump, seq_pop_pc, int_ack, instr_done;
    logic        nmi_executing, lvl1_executing, lvl0_executing;
    logic [7:0]  int_vector, active_vector, normal_priority_base;
    logic [15:0] vector_addr;
    logic [7:0]  bases [3] = '{8'h00, 8'h05, 8'h07};
    logic [7:0]  wins [4] = '{8'h05, 8'h07, 8'h05, 8'h07};
    int          n_mismatch = 0, compares = 0, np, nj, pre;

    always #2.5 sys_clk = ~sys_clk;

    cip_top dut_u (.sys_clk, .reset_n, .irq_lines, .global_enable, .vector_base_select,
        .compact_table_enable, .round_robin_enable, .high_level_vector, .prio_base_wr,
        .prio_base_wdata, .app_vector_base, .instr_done, .cpu_sleeping,
        .wake_startup_cycles, .int_ack, .return_from_handler_exec, .int_req, .int_vector, .seq_push_pc,
        .seq_jump, .seq_pop_pc, .active_vector, .vector_addr, .normal_priority_base,
        .nmi_executing, .lvl1_executing, .lvl0_executing);
    cip_cpu_model cpu_u (.sys_clk, .reset_n, .int_req, .ack_en, .hold, .int_ack,
        .instr_done);

    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    // count push and jump cycles, and wake or finish cycles before the first push
    task automatic seqcnt();
        np = 0;
        nj = 0;
        pre = 1; // the cycle right after a take falls before this window
        repeat (16)
        begin
            @(negedge sys_clk);
            if (seq_push_pc === 1'h1) np++;
            else if (np == 0) pre++;
            if (seq_jump === 1'h1) nj++;
        end
    endtask : seqcnt

    // open the acknowledge window, wait bounded for the take, then follow it
    task automatic take(input logic [7:0] v, input logic [7:0] av, input logic [2:0] fl);
        int          i;
        logic [15:0] ea;
        @(posedge sys_clk) ack_en <= 1'h1;
        // placement inputs set in the caller's time step have settled by now
        ea = (vector_base_select ? BOOT_VEC_BASE : app_vector_base) + 16'(av) * VEC_STRIDE;
        i = 0;
        do
        begin
            @(negedge sys_clk);
            i++;
        end
        while (!(int_req === 1'h1 && int_ack === 1'h1) && i < 60);
        chk("ack_seen", 16'(int_ack), 16'h0001);
        chk("int_vector", int_vector, v);
        @(posedge sys_clk) ack_en <= 1'h0;
        @(negedge sys_clk);
        chk("active_vector", active_vector, av);
        chk("vector_addr", vector_addr, ea);
        chk("levels", {nmi_executing, lvl1_executing, lvl0_executing}, fl);
        seqcnt();
        chk("push_cycles", 16'(np), hold ? 16'h0000 : 16'(PUSH_CYC));
        if (!hold) chk("jump_cycles", 16'(nj), 16'(JUMP_LEN));
    endtask : take

    // the gap before the return lets any step state after hold finish
    task automatic ret(input logic [2:0] fl);
        int n;
        repeat (3) @(posedge sys_clk);
        return_from_handler_exec <= 1'h1;
        @(posedge sys_clk) return_from_handler_exec <= 1'h0;
        n = 0;
        repeat (6)
        begin
            @(negedge sys_clk);
            n += int'(seq_pop_pc === 1'h1);
        end
        chk("pop_cycles", 16'(n), 16'(RET_LEN));
        chk("levels", {nmi_executing, lvl1_executing, lvl0_executing}, fl);
    endtask : ret

    task automatic wrap_up();
        $display("compares %0d mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : wrap_up

    ////////////////////////////////////////////////////////////////////////////
    // whole run is under a thousand cycles; four thousand means a hang
    initial
    begin
        #20000;
        n_mismatch++;
        wrap_up();
    end

    initial
    begin
        repeat (12) @(posedge sys_clk);
        reset_n <= 1'h1;
        @(negedge sys_clk);
        chk("levels", {nmi_executing, lvl1_executing, lvl0_executing}, 3'h0);
        chk("prio_base", normal_priority_base, PRIO_BASE_RST);
        // controller options stay default, peripheral lines first, global enable last
        @(posedge sys_clk) irq_lines[5] <= 1'h1;
        repeat (4) @(negedge sys_clk);
        chk("masked_req", int_req, 1'h0);
        @(posedge sys_clk) irq_lines[1] <= 1'h1;
        take(8'h01, 8'h01, 3'h4);
        @(posedge sys_clk) global_enable <= 1'h1;
        repeat (3) @(negedge sys_clk);
        chk("nmi_blocks", int_req, 1'h0);
        @(posedge sys_clk) irq_lines[1] <= 1'h0;
        ret(3'h0);
        $display("test nmi done");
        take(8'h05, 8'h05, 3'h1);
        @(posedge sys_clk) irq_lines[7] <= 1'h1;
        repeat (3) @(negedge sys_clk);
        chk("same_level_wait", int_req, 1'h0);
        @(posedge sys_clk) high_level_vector <= 8'h09;
        @(posedge sys_clk) irq_lines[9] <= 1'h1;
        take(8'h09, 8'h09, 3'h3);
        @(posedge sys_clk) hold <= 1'h1;
        ret(3'h1);
        chk("step_after_ret", int_req, 1'h0);
        @(posedge sys_clk) irq_lines[9] <= 1'h0;
        hold <= 1'h0;
        ret(3'h0);
        $display("test nesting done");
        // static order from several bases, the last one wrapping round
        for (int k = 0; k < 3; k++)
        begin
            @(posedge sys_clk) prio_base_wr <= 1'h1;
            prio_base_wdata <= bases[k];
            @(posedge sys_clk) prio_base_wr <= 1'h0;
            take(wins[k], wins[k], 3'h1);
            ret(3'h0);
        end
        @(posedge sys_clk) round_robin_enable <= 1'h1;
        for (int k = 2; k < 4; k++)
        begin
            take(wins[k], wins[k], 3'h1);
            chk("rr_base", normal_priority_base, wins[k]);
            ret(3'h0);
        end
        $display("test scheduling done");
        @(posedge sys_clk) round_robin_enable <= 1'h0;
        compact_table_enable <= 1'h1;
        vector_base_select <= 1'h1;
        take(8'h05, CVT_LVL0_VEC, 3'h1);
        ret(3'h0);
        @(posedge sys_clk) compact_table_enable <= 1'h0;
        vector_base_select <= 1'h0;
        // with and without start-up time, so the bare five cycles are seen too
        for (int w = 0; w < 2; w++)
        begin
            @(posedge sys_clk) cpu_sleeping <= 1'h1;
            wake_startup_cycles <= 8'(2 * w);
            take(8'h05, 8'h05, 3'h1);
            chk("wake_cycles", 16'(pre), 16'(WAKE_EXTRA_CYC) + 16'(2 * w));
            @(posedge sys_clk) cpu_sleeping <= 1'h0;
            ret(3'h0);
        end
        @(posedge sys_clk) hold <= 1'h1;
        take(8'h05, 8'h05, 3'h1);
        @(posedge sys_clk) hold <= 1'h0;
        seqcnt();
        chk("late_push", 16'(np), 16'(PUSH_CYC));
        chk("late_jump", 16'(nj), 16'(JUMP_LEN));
        ret(3'h0);
        $display("test timing done");
        wrap_up();
    end
endmodule : cpu_interrupt_prioritizer_tb
